// *** rtl/gss_pkg.sv ***
/*
  Shared constants for the gain set switcher: register indices, field
  positions, reset values, switching sources and timing figures.
  Assumes a single 40 MHz clock and a plain strobe-driven register port.
*/
package gss_pkg;

  // Width of one parameter word and of the register index.
  localparam int unsigned DW     = 16;
  localparam int unsigned REG_AW = 5;

  // Number of filtered gains and of directly switched vibration values.
  localparam int unsigned NUM_GAINS = 5;
  localparam int unsigned NUM_VIB   = 8;

  // Register indices; one word per index on the register port.
  localparam logic [4:0] IDX_TUNING    = 5'h00;  // Tuning mode setting.
  localparam logic [4:0] IDX_SELECT    = 5'h01;  // Switch select setting.
  localparam logic [4:0] IDX_LEVEL     = 5'h02;  // Switch level setting.
  localparam logic [4:0] IDX_TIMECONST = 5'h03;  // Filter time constant in ms.
  localparam logic [4:0] IDX_STATUS    = 5'h04;  // Read-only status word.
  localparam logic [4:0] IDX_GAIN_BASE = 5'h05;  // Five before-switching gains.
  localparam logic [4:0] IDX_GAIN_ALT  = 5'h0a;  // Five after-switching gains.
  localparam logic [4:0] IDX_VIB_BASE  = 5'h0f;  // Eight before-switching vib values.
  localparam logic [4:0] IDX_VIB_ALT   = 5'h17;  // Eight after-switching vib values.
  localparam logic [4:0] IDX_LAST      = 5'h1e;  // Highest mapped index.

  // Gain order within the base and alternate groups.
  localparam int unsigned GAIN_INERTIA  = 0;
  localparam int unsigned GAIN_MODEL    = 1;
  localparam int unsigned GAIN_POSITION = 2;
  localparam int unsigned GAIN_SPEED    = 3;
  localparam int unsigned GAIN_INTEGRAL = 4;

  // Tuning mode field and the manual code.
  localparam int unsigned TUNING_LSB    = 0;
  localparam logic [3:0]  TUNING_MANUAL = 4'h3;

  // Switch select: first digit is the source, second digit the polarity.
  localparam int unsigned SEL_SRC_LSB = 0;
  localparam int unsigned SEL_POL_LSB = 4;
  localparam logic [3:0]  POL_ABOVE   = 4'h0;
  localparam logic [3:0]  POL_BELOW   = 4'h1;

  // Status word bit positions.
  localparam int unsigned ST_SWITCH = 0;
  localparam int unsigned ST_VIB    = 1;
  localparam int unsigned ST_MANUAL = 2;

  // Reset value of every writable register.
  localparam logic [15:0] RST_WORD = 16'h0000;

  // Clock rate and the millisecond tick derived from it.
  localparam int unsigned CLK_HZ     = 40_000_000;
  localparam int unsigned TICK_MS    = 1;
  localparam int unsigned MS_PER_S   = 1000;
  localparam int unsigned MS_CYCLES  = CLK_HZ / MS_PER_S * TICK_MS;

  // Switching sources held in the first digit of the select setting.
  typedef enum logic [3:0] {
    SRC_NONE  = 4'b0000,
    SRC_CMD   = 4'b0001,
    SRC_FREQ  = 4'b0010,
    SRC_DROOP = 4'b0011,
    SRC_SPEED = 4'b0100
  } gss_src_t;

endpackage : gss_pkg

// *** rtl/gss_lag_filter.sv ***
/*
  First-order lag stage that walks one gain toward its target once per
  millisecond tick. Assumes the tick is a one-cycle enable on the same clock.
*/
`timescale 1ns/1ps
module gss_lag_filter #(
  parameter int unsigned W = 16
) (
  // Clock and synchronous-domain reset.
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  // Update enable and time constant in ms.
  input  wire logic         tick_in,
  input  wire logic [15:0]  tc_in,
  // Target value and filtered output.
  input  wire logic [W-1:0] target_in,
  output logic      [W-1:0] y_out
);

  // Refuse widths narrower than the time constant, which would cut the step silently.
  if (W < 16 || W > 32) begin : g_bad_width
    $error("W out of range");
  end

  // Signed difference, one bit wider than the data.
  logic signed [W:0] diff_w;
  // Step taken on a tick.
  logic signed [W:0] step_w;

  // Step is the difference divided by the time constant, at least one unit.
  always_comb begin
    diff_w = $signed({1'b0, target_in}) - $signed({1'b0, y_out});
    step_w = diff_w / $signed({1'b0, tc_in});
    if (tc_in == 16'h0000) begin
      // Zero time constant takes the target at once.
      step_w = diff_w;
    end else if (step_w == '0 && diff_w != '0) begin
      // Never stall short of the target.
      step_w = (diff_w < 0) ? -$signed((W+1)'(1)) : $signed((W+1)'(1));
    end
  end

  // Output moves by one step per tick.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      y_out <= '0;
    end else if (tick_in) begin
      y_out <= W'($signed({1'b0, y_out}) + step_w); // R05
    end
  end

endmodule : gss_lag_filter

// *** rtl/gss_switcher.sv ***
/*
  Gain set switcher: register file, switching condition, vibration value
  latch and five lag filters for the switched gains.
  Assumes measured quantities and motor stop flag come from logic on clk_in,
  while the host switching command arrives on a pin.
*/
// Contract
// [R01] Switching only in manual tuning mode.
// [R02] Gains follow selected condition and level.
// [R03] Condition decoded from select digits one, two.
// [R04] Measured quantity compared against level setting.
// [R05] Each switched gain passes lag filter.
// [R06] Alternate inertia and loop gains replace base.
// [R07] Vibration values change only when stopped.
// [R08] Vibration and model alternates need host command.
// [R09] Host equalises inertia alternates if unchanged.
// [R10] Select value 0001 means host command.
// [R11] Condition release returns to base through filter.
`timescale 1ns/1ps
module gss_switcher #(
  parameter int unsigned MS_CYCLES = gss_pkg::MS_CYCLES
) (
  // Clock and reset.
  input  wire logic                     clk_in,
  input  wire logic                     arst_n_in,
  // Register port.
  input  wire logic [4:0]               addr_in,
  input  wire logic [15:0]              wr_data_in,
  input  wire logic                     wr_en_in,
  input  wire logic                     rd_en_in,
  output logic      [15:0]              rd_data_out,
  // Switching sources.
  input  wire logic                     host_cmd_in,
  input  wire logic [15:0]              cmd_freq_in,
  input  wire logic [15:0]              droop_in,
  input  wire logic [15:0]              speed_in,
  input  wire logic                     motor_stopped_in,
  // Applied parameters.
  output logic [gss_pkg::NUM_GAINS-1:0][15:0] gains_out,
  output logic [gss_pkg::NUM_VIB-1:0][15:0]   vib_out,
  output logic                          switched_out
);

  // Refuse a tick period the divider cannot count.
  if (MS_CYCLES < 1 || MS_CYCLES > 65536) begin : g_bad_tick
    $error("MS_CYCLES out of range");
  end

  // Reset synchroniser stages.
  logic        rst_meta_q;
  logic        rst_n;
  // Host command synchroniser stages.
  logic        cmd_meta_q;
  logic        cmd_sync_q;
  // Register array; index 4 and 31 are not stored.
  logic [15:0] regs_q [0:31];
  // Millisecond divider and tick.
  logic [15:0] div_q;
  logic        tick_q;
  // Switching state, vibration selection and combinational helpers.
  logic        switch_q;
  logic        vib_sel_q;
  logic        manual_w;
  logic        cond_w;
  logic        src_cmd_w;
  gss_pkg::gss_src_t src_w;
  logic [3:0]  pol_w;
  logic [gss_pkg::NUM_GAINS-1:0][15:0] target_w;
  logic [15:0] vib_q [0:gss_pkg::NUM_VIB-1];

  // Index may be written by software.
  function automatic logic writable(input logic [4:0] idx);
    writable = (idx != gss_pkg::IDX_STATUS) && (idx <= gss_pkg::IDX_LAST);
  endfunction : writable

  // Compare a quantity with the level in the chosen direction.
  function automatic logic level_hit(input logic [15:0] q, input logic [15:0] lvl,
                                     input logic [3:0] pol);
    level_hit = (pol == gss_pkg::POL_BELOW) ? (q < lvl) : (q >= lvl);
  endfunction : level_hit

  // Release reset through two flip-flops.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // Bring the host command pin into the clock domain.
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cmd_meta_q <= 1'b0;
      cmd_sync_q <= 1'b0;
    end else begin
      cmd_meta_q <= host_cmd_in;
      cmd_sync_q <= cmd_meta_q;
    end
  end

  // Store software writes; unmapped and read-only indices are ignored.
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 32; i++) begin
        regs_q[i] <= gss_pkg::RST_WORD;
      end
    end else if (wr_en_in && writable(addr_in)) begin
      regs_q[addr_in] <= wr_data_in;
    end
  end

  // Return read data in the cycle after the read strobe, zero otherwise.
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_out <= 16'h0000;
    end else if (rd_en_in && addr_in == gss_pkg::IDX_STATUS) begin
      rd_data_out <= 16'h0000;
      rd_data_out[gss_pkg::ST_SWITCH] <= switch_q;
      rd_data_out[gss_pkg::ST_VIB]    <= vib_sel_q;
      rd_data_out[gss_pkg::ST_MANUAL] <= manual_w;
    end else if (rd_en_in && writable(addr_in)) begin
      rd_data_out <= regs_q[addr_in];
    end else begin
      rd_data_out <= 16'h0000;
    end
  end

  // Millisecond tick divider paces the lag filters.
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      div_q  <= 16'h0000;
      tick_q <= 1'b0;
    end else if (div_q == 16'(MS_CYCLES - 1)) begin
      div_q  <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  // Decode the select digits and evaluate the chosen condition.
  always_comb begin
    manual_w = regs_q[gss_pkg::IDX_TUNING][gss_pkg::TUNING_LSB +: 4]
               == gss_pkg::TUNING_MANUAL;
    src_w    = gss_pkg::gss_src_t'(regs_q[gss_pkg::IDX_SELECT][gss_pkg::SEL_SRC_LSB +: 4]); // R03
    pol_w    = regs_q[gss_pkg::IDX_SELECT][gss_pkg::SEL_POL_LSB +: 4]; // R03
    src_cmd_w = (src_w == gss_pkg::SRC_CMD);
    unique case (src_w)
      gss_pkg::SRC_NONE:  cond_w = 1'b0;
      gss_pkg::SRC_CMD:   cond_w = cmd_sync_q; // R10
      gss_pkg::SRC_FREQ:  cond_w = level_hit(cmd_freq_in, regs_q[gss_pkg::IDX_LEVEL], pol_w); // R04
      gss_pkg::SRC_DROOP: cond_w = level_hit(droop_in, regs_q[gss_pkg::IDX_LEVEL], pol_w); // R04
      gss_pkg::SRC_SPEED: cond_w = level_hit(speed_in, regs_q[gss_pkg::IDX_LEVEL], pol_w); // R04
      default:            cond_w = 1'b0;
    endcase
  end

  // Switch state follows the condition, and only in manual mode.
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      switch_q <= 1'b0;
    end else begin
      switch_q <= manual_w && cond_w; // R01 R02 R11
    end
  end

  // Choose filter targets: alternates while switched (model alternate only under host command), base otherwise.
  always_comb begin
    for (int g = 0; g < int'(gss_pkg::NUM_GAINS); g++) begin
      target_w[g] = switch_q ? regs_q[gss_pkg::IDX_GAIN_ALT + 5'(g)] // R06
                             : regs_q[gss_pkg::IDX_GAIN_BASE + 5'(g)]; // R11
    end
    if (!src_cmd_w) begin
      // Model alternate is for host command switching only.
      target_w[gss_pkg::GAIN_MODEL] = regs_q[gss_pkg::IDX_GAIN_BASE
                                             + 5'(gss_pkg::GAIN_MODEL)]; // R08
    end
  end

  // One lag stage per switched gain.
  for (genvar g = 0; g < gss_pkg::NUM_GAINS; g++) begin : g_filt
    gss_lag_filter #(.W(16)) u_filt (
      .clk_in    (clk_in),
      .rst_n_in  (rst_n),
      .tick_in   (tick_q),
      .tc_in     (regs_q[gss_pkg::IDX_TIMECONST]),
      .target_in (target_w[g]),
      .y_out     (gains_out[g])
    ); // R05
  end

  // Vibration set is taken over only while stopped, under host command.
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      vib_sel_q <= 1'b0;
    end else if (motor_stopped_in) begin // R07
      vib_sel_q <= switch_q && src_cmd_w; // R08
    end
  end

  // Vibration outputs are registered copies of the selected set.
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      for (int v = 0; v < int'(gss_pkg::NUM_VIB); v++) begin
        vib_q[v] <= 16'h0000;
      end
    end else begin
      for (int v = 0; v < int'(gss_pkg::NUM_VIB); v++) begin
        vib_q[v] <= vib_sel_q ? regs_q[gss_pkg::IDX_VIB_ALT + 5'(v)]
                              : regs_q[gss_pkg::IDX_VIB_BASE + 5'(v)]; // R07
      end
    end
  end

  // Flatten the vibration registers onto the output port.
  always_comb begin
    for (int v = 0; v < int'(gss_pkg::NUM_VIB); v++) begin
      vib_out[v] = vib_q[v];
    end
  end

  // Switch state indicator.
  assign switched_out = switch_q;

  // Checks run on the released reset.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  chk_auto_blocks: assert property (!manual_w |=> !switch_q) // R01
    else $error("switch active outside manual mode");
  chk_cmd_source: assert property (manual_w && src_cmd_w && cmd_sync_q |=> switch_q) // R10
    else $error("host command did not switch");
  chk_speed_level: assert property (manual_w && src_w == gss_pkg::SRC_SPEED
      && pol_w == gss_pkg::POL_ABOVE && speed_in >= regs_q[gss_pkg::IDX_LEVEL]
      |=> switch_q) // R04
    else $error("speed above level did not switch");
  chk_release_base: assert property (!switch_q && src_cmd_w |->
      target_w[gss_pkg::GAIN_SPEED] == regs_q[gss_pkg::IDX_GAIN_BASE + 5'h3]) // R11
    else $error("released switch not aimed at base");
  chk_alt_target: assert property (switch_q |->
      target_w[gss_pkg::GAIN_POSITION] == regs_q[gss_pkg::IDX_GAIN_ALT + 5'h2]) // R06
    else $error("switched gain not aimed at alternate");
  chk_vib_moving: assert property (!motor_stopped_in |=> $stable(vib_sel_q)) // R07
    else $error("vibration set changed while moving");
  chk_vib_cmd_only: assert property (!src_cmd_w && motor_stopped_in |=> !vib_sel_q) // R08
    else $error("vibration alternate under measured source");
  chk_model_base: assert property (!src_cmd_w |->
      target_w[gss_pkg::GAIN_MODEL] == regs_q[gss_pkg::IDX_GAIN_BASE + 5'h1]) // R08
    else $error("model alternate under measured source");
  chk_tc_zero: assert property (tick_q && regs_q[gss_pkg::IDX_TIMECONST] == 16'h0000
      |=> gains_out[0] == $past(target_w[0])) // R05
    else $error("zero time constant did not jump");

  cov_cmd_switch:  cover property (src_cmd_w && $rose(switch_q));
  cov_droop_switch: cover property (src_w == gss_pkg::SRC_DROOP && $rose(switch_q));
  cov_vib_taken:   cover property ($rose(vib_sel_q));
  cov_release:     cover property ($fell(switch_q));

endmodule : gss_switcher

// *** tb/gss_host_model.sv ***
/*
  Model of the host controller that raises and drops the switching command.
  Assumes the bench requests a level on want_in and a reply delay on lag_in.
*/
`timescale 1ns/1ps
module gss_host_model (
  // Clock and reset.
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  // Requested command level and reply delay in cycles.
  input  wire logic       want_in,
  input  wire logic [3:0] lag_in,
  // Command pin toward the switcher.
  output logic            host_cmd_out
);
  logic [3:0] wait_q;  // Cycles left before the pin follows the request.

  // The pin follows the request lag_in + 1 cycles after it changes, as a slow host would.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      host_cmd_out <= 1'b0;
      wait_q       <= 4'h0;
    end else if (want_in == host_cmd_out) begin
      wait_q <= lag_in;
    end else if (wait_q == 4'h0) begin
      host_cmd_out <= want_in;
    end else begin
      wait_q <= wait_q - 4'h1;
    end
  end
endmodule : gss_host_model

// *** tb/testbench.sv ***
/*
  Self-checking bench for the gain set switcher.
  Assumes the host model drives the command pin and a shortened ms tick.
*/
`timescale 1ns/1ps
module testbench;
  localparam int MS = 4;  // Shortened millisecond tick in cycles.
  typedef struct {logic [4:0] a; logic [15:0] d; logic [15:0] e;} gss_row_t;

  logic             clk_in    = 1'b0;   // Bench clock.
  logic             arst_n_in = 1'b0;   // Reset, active low.
  logic             wr_en     = 1'b0;   // Write strobe.
  logic             rd_en     = 1'b0;   // Read strobe.
  logic [4:0]       addr      = 5'h00;  // Register index.
  logic [15:0]      wdata     = 16'h0000;
  logic [15:0]      freq      = 16'h0000;
  logic [15:0]      droop     = 16'h0000;
  logic [15:0]      speed     = 16'h0000;
  logic             want      = 1'b0;   // Requested host command.
  logic             stopped   = 1'b1;   // Motor stopped flag.
  logic [3:0]       lag       = 4'h0;   // Host reply delay.
  logic             host_cmd;
  logic             sw;
  logic [15:0]      rdata;
  logic [4:0][15:0] gains;
  logic [7:0][15:0] vib;
  int               fails     = 0;
  int               tests_run = 0;

  // Register rows: index, written word, word read back.
  gss_row_t rows [6] = '{
    '{gss_pkg::IDX_TUNING,    16'h0000, 16'h0000},
    '{gss_pkg::IDX_SELECT,    16'h0001, 16'h0001},
    '{gss_pkg::IDX_LEVEL,     16'h0064, 16'h0064},
    '{gss_pkg::IDX_TIMECONST, 16'h0000, 16'h0000},
    '{gss_pkg::IDX_STATUS,    16'hffff, 16'h0000},
    '{5'h1f,                  16'hffff, 16'h0000}};

  gss_switcher #(.MS_CYCLES(MS)) gss_switcher_inst (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr), .wr_data_in(wdata),
    .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rdata), .host_cmd_in(host_cmd),
    .cmd_freq_in(freq), .droop_in(droop), .speed_in(speed),
    .motor_stopped_in(stopped), .gains_out(gains), .vib_out(vib), .switched_out(sw));

  gss_host_model gss_host_model_inst (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .want_in(want), .lag_in(lag),
    .host_cmd_out(host_cmd));

  // Free-running 40 MHz clock.
  initial begin
    forever #12.5 clk_in = ~clk_in;
  end

  // Prints the verdict and ends the run.
  task automatic stop_test();
    if (fails == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  // Compares one word and counts the outcome.
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // One-cycle write strobe; the entry edge keeps strobes apart.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_in);
    wr_en <= 1'b0;
  endtask : wr

  // One-cycle read strobe; data is looked at in the following cycle.
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk_in);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk_in);
    rd_en <= 1'b0;
    @(negedge clk_in);
    cmp(rdata, e);
  endtask : rd

  // Lets n edges pass and stops where outputs are settled.
  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask : settle

  // Sets the host request and waits for the pin, sync and tick.
  task automatic host(input logic v);
    @(posedge clk_in);
    want <= v;
    settle(20);
  endtask : host

  // Drives only the measured quantity chosen by source s.
  task automatic meas(input int s, input logic [15:0] v);
    @(posedge clk_in);
    freq  <= (s == 2) ? v : 16'h0000;
    droop <= (s == 3) ? v : 16'h0000;
    speed <= (s == 4) ? v : 16'h0000;
    settle(12);
  endtask : meas

  // Checks the applied set: g gains, m model gain, v vibration values.
  task automatic chk_set(input logic g, input logic m, input logic v);
    for (int k = 0; k < 5; k++) begin
      cmp(gains[k], 16'h0105 + 16'(k) + ((((k == 1) ? m : g)) ? 16'h0005 : 16'h0000));
    end
    for (int k = 0; k < 8; k++) begin
      cmp(vib[k], 16'h010f + 16'(k) + (v ? 16'h0008 : 16'h0000));
    end
  endtask : chk_set

  // Watchdog against a hang.
  initial begin
    repeat (6000) @(posedge clk_in);
    fails++;
    stop_test();
  end

  // Main sequence.
  initial begin
    repeat (4) @(posedge clk_in);
    arst_n_in <= 1'b1;
    settle(3);
    cmp(gains[2], 16'h0000);
    rd(gss_pkg::IDX_LEVEL, 16'h0000);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    for (int i = 5; i < 31; i++) begin
      wr(5'(i), 16'h0100 + 16'(i));
    end
    // Automatic tuning keeps the base set despite the command.
    host(1'b1);
    cmp({15'h0000, sw}, 16'h0000);
    chk_set(1'b0, 1'b0, 1'b0);
    wr(gss_pkg::IDX_TUNING, 16'h0003);
    settle(12);
    cmp({15'h0000, sw}, 16'h0001);
    chk_set(1'b1, 1'b1, 1'b1);
    rd(gss_pkg::IDX_STATUS, 16'h0007);
    host(1'b0);
    chk_set(1'b0, 1'b0, 1'b0);
    // A running motor keeps the base vibration values; the host is slow.
    @(posedge clk_in);
    stopped <= 1'b0;
    lag     <= 4'h3;
    host(1'b1);
    chk_set(1'b1, 1'b1, 1'b0);
    host(1'b0);
    @(posedge clk_in);
    stopped <= 1'b1;
    // Each measured source, at the level and one below it.
    for (int s = 2; s < 5; s++) begin
      wr(gss_pkg::IDX_SELECT, 16'(s));
      meas(s, 16'h0064);
      chk_set(1'b1, 1'b0, 1'b0);
      meas(s, 16'h0063);
      chk_set(1'b0, 1'b0, 1'b0);
    end
    // Time constant 2 halves the remaining distance each tick.
    wr(gss_pkg::IDX_TIMECONST, 16'h0002);
    @(posedge clk_in);
    speed <= 16'h0064;
    for (int i = 0; i < 20 && gains[0] === 16'h0105; i++) begin
      @(posedge clk_in);
    end
    #1;
    cmp(gains[0], 16'h0107);
    settle(40);
    cmp(gains[0], 16'h010a);
    // Second digit turns the comparison round.
    wr(gss_pkg::IDX_SELECT, 16'h0014);
    meas(4, 16'h0063);
    cmp({15'h0000, sw}, 16'h0001);
    // Equal inertia in both sets: the inertia gain must not move on a switch.
    wr(gss_pkg::IDX_GAIN_ALT, 16'h0105);
    settle(30);
    cmp(gains[0], 16'h0105);
    meas(4, 16'h0064);
    cmp({15'h0000, sw}, 16'h0000);
    cmp(gains[0], 16'h0105);
    // Source code zero never switches, whatever the quantity.
    wr(gss_pkg::IDX_SELECT, 16'h0010);
    meas(4, 16'h0063);
    cmp({15'h0000, sw}, 16'h0000);
    stop_test();
  end
endmodule : testbench
